// [common/pin_remap_consts.svh]
// Purpose: Offsets, field positions, reset values of the high remap register
// Assumes: Byte addressing on the plain register port
// Notes: Definitions only
`ifndef PIN_REMAP_CONSTS_SVH
`define PIN_REMAP_CONSTS_SVH

`define REMAP_ADDR_W 8
`define REMAP_CONFIG_HIGH_OFS 8'h00
`define REMAP_CONFIG_HIGH_RST 32'h0000_0000
// Writable bits 25:16 (bit 17 kept as a plain reserved storage bit)
`define REMAP_CONFIG_HIGH_WMASK 32'h03ff_0000
`define REMAP_UNMAPPED_RDATA 32'h0000_0000

`define LOWPOWER_TIMER_SEL_BIT 25
`define SERIAL_PERIPH_SEL_HI_BIT 24
`define TWOWIRE_SEL_HI_BIT 23
`define ADV_TIMER_SEL_HI_BIT 22
`define GEN_TIMER_SEL_HI_BIT 21
`define SERIAL_PORT_A_SEL_HI_MSB 20
`define SERIAL_PORT_A_SEL_HI_LSB 19
`define SERIAL_PORT_B_SEL_HI_BIT 18
`define RESERVED_RW_BIT 17
`define SERIAL_PORT_D_SEL_BIT 16

`define PIN_CODE_W 5

`endif

// [common/pin_remap_pkg.sv]
// Purpose: Types shared by the pin remap block
// Assumes: Pin code is {port, pin number}, port A = 0, port B = 1
// Notes: Constants live in pin_remap_consts.svh
package pin_remap_pkg;

  typedef logic [4:0] pin_t;
  typedef logic [1:0] code2_t;
  typedef logic [2:0] code3_t;

  function automatic pin_t pa(input logic [3:0] n);
    return {1'b0, n};
  endfunction

  function automatic pin_t pb(input logic [3:0] n);
    return {1'b1, n};
  endfunction

endpackage

// [core/peripheral_pin_remap_high.sv]
// Purpose: High remap control register and pin routing select decode
// Assumes: Low-order select bits arrive from the first remap register
// Notes: Pin codes are {port, number}; unlisted codes fall to defaults
//
// Contract
// - Bit 25 picks low-power timer pin set
// - Serial periph codes 00/01 place four pins
// - Serial periph codes 10/11 differ only select
// - Two-wire codes 00/10/11; alert stays PB5
// - Adv timer code 000 default pin set
// - Adv timer 001 moves break, complementary
// - Adv timer 010/011 share; trigger differs
// - Adv timer code 100 mapping
// - Adv timer code 101 mapping
// - Adv timer 111 routes oscillator, no pins
// - Gen timer codes 000 through 011
// - Gen timer codes 100 and 101
// - Gen timer code 111 mapping
// - Bits 20:19 port A high, reset 00
// - Serial port A six pin codes
// - Serial port B codes; 01 reserved
// - Bit 16 picks serial port D set
// - Reserved bits read zero; bit 17 writable
// - Low bits from first remap register
`timescale 1ns/1ps
`include "pin_remap_consts.svh"
module peripheral_pin_remap_high
  import pin_remap_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [`REMAP_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic serial_periph_pin_sel_lo_i,
  input wire logic twowire_pin_sel_lo_i,
  input wire logic [1:0] adv_timer_pin_sel_lo_i,
  input wire logic [1:0] gen_timer_pin_sel_lo_i,
  input wire logic serial_port_a_pin_sel_lo_i,
  input wire logic serial_port_b_pin_sel_lo_i,
  output pin_t [3:0] lowpower_timer_pins_o,
  output pin_t [3:0] serial_periph_pins_o,
  output pin_t [2:0] twowire_pins_o,
  output pin_t [8:0] adv_timer_pins_o,
  output logic adv_timer_pins_en_o,
  output logic low_speed_internal_osc_cal_o,
  output pin_t [3:0] gen_timer_pins_o,
  output pin_t [4:0] serial_port_a_pins_o,
  output pin_t [4:0] serial_port_b_pins_o,
  output pin_t [4:0] serial_port_d_pins_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and bus

  logic [31:0] remap_config_high_r;
  logic [31:0] remap_config_high_nxt;
  logic hit_high;

  assign hit_high = (addr_i == `REMAP_CONFIG_HIGH_OFS);

  always_comb begin
    remap_config_high_nxt = remap_config_high_r;
    if (wr_i && hit_high) begin
      remap_config_high_nxt = wdata_i & `REMAP_CONFIG_HIGH_WMASK;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remap_config_high_r <= `REMAP_CONFIG_HIGH_RST;
    end else begin
      remap_config_high_r <= remap_config_high_nxt;
    end
  end

  // Unmapped reads answer zero rather than stale data
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      if (hit_high) begin
        rdata_o <= remap_config_high_r;
      end else begin
        rdata_o <= `REMAP_UNMAPPED_RDATA;
      end
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code assembly

  logic lowpower_timer_pin_sel;
  code2_t serial_periph_code;
  code2_t twowire_code;
  code3_t adv_timer_code;
  code3_t gen_timer_code;
  code3_t serial_port_a_code;
  code2_t serial_port_b_code;
  logic serial_port_d_pin_sel;

  // high bit over first-register low part
  assign serial_periph_code = {remap_config_high_r[`SERIAL_PERIPH_SEL_HI_BIT],
                               serial_periph_pin_sel_lo_i};
  assign twowire_code = {remap_config_high_r[`TWOWIRE_SEL_HI_BIT], twowire_pin_sel_lo_i};
  // Both bits of the two-bit first-register field form the low part
  assign adv_timer_code = {remap_config_high_r[`ADV_TIMER_SEL_HI_BIT],
                           adv_timer_pin_sel_lo_i};
  assign gen_timer_code = {remap_config_high_r[`GEN_TIMER_SEL_HI_BIT],
                           gen_timer_pin_sel_lo_i};
  assign serial_port_a_code = {remap_config_high_r[`SERIAL_PORT_A_SEL_HI_MSB:
                                                   `SERIAL_PORT_A_SEL_HI_LSB],
                               serial_port_a_pin_sel_lo_i};
  assign serial_port_b_code = {remap_config_high_r[`SERIAL_PORT_B_SEL_HI_BIT],
                               serial_port_b_pin_sel_lo_i};
  assign lowpower_timer_pin_sel = remap_config_high_r[`LOWPOWER_TIMER_SEL_BIT];
  assign serial_port_d_pin_sel = remap_config_high_r[`SERIAL_PORT_D_SEL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Decode: low-power timer {ch1, ch2, trigger, compare}

  pin_t [3:0] lowpower_timer_pins_nxt;

  always_comb begin
    if (lowpower_timer_pin_sel) begin
      lowpower_timer_pins_nxt = {pb(4'h2), pb(4'h6), pb(4'h7), pb(4'h5)};
    end else begin
      lowpower_timer_pins_nxt = {pb(4'hf), pb(4'he), pb(4'hd), pb(4'hc)};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode: serial peripheral {master-out, master-in, clock, select}

  pin_t [3:0] serial_periph_pins_nxt;

  always_comb begin
    case (serial_periph_code)
      2'h1: serial_periph_pins_nxt = {pb(4'h5), pb(4'h4), pb(4'h3), pa(4'hf)};
      2'h2: serial_periph_pins_nxt = {pb(4'h7), pb(4'h8), pb(4'h6), pa(4'hc)};
      2'h3: serial_periph_pins_nxt = {pb(4'h7), pb(4'h8), pb(4'h6), pb(4'hc)};
      default: serial_periph_pins_nxt = {pa(4'h7), pa(4'h6), pa(4'h5), pa(4'h4)};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode: two-wire bus {alert, data, clock}

  pin_t [2:0] twowire_pins_nxt;

  always_comb begin
    case (twowire_code)
      2'h2: twowire_pins_nxt = {pb(4'h5), pa(4'hc), pa(4'hd)};
      2'h3: twowire_pins_nxt = {pb(4'h5), pb(4'hb), pb(4'h9)};
      default: twowire_pins_nxt = {pb(4'h5), pb(4'h7), pb(4'h6)};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode: advanced timer
  // Order {ch3n, ch2n, ch1n, break, ch4, ch3, ch2, ch1, trigger}

  pin_t [8:0] adv_timer_pins_nxt;
  logic adv_timer_pins_en_nxt;
  logic osc_cal_nxt;

  always_comb begin
    adv_timer_pins_en_nxt = 1'b1;
    osc_cal_nxt = 1'b0;
    case (adv_timer_code)
      3'h1: adv_timer_pins_nxt = {pb(4'h1), pb(4'h0), pa(4'h7), pa(4'h6),
                                  pa(4'hb), pa(4'ha), pa(4'h9), pa(4'h8), pa(4'hc)};
      3'h2: adv_timer_pins_nxt = {pb(4'h9), pb(4'h0), pb(4'hb), pa(4'hd),
                                  pb(4'h1), pa(4'he), pa(4'h7), pa(4'h1), pb(4'h6)};
      3'h3: adv_timer_pins_nxt = {pb(4'h9), pb(4'h0), pb(4'hb), pa(4'hd),
                                  pb(4'h1), pa(4'he), pa(4'h7), pa(4'h1), pa(4'h3)};
      3'h4: adv_timer_pins_nxt = {pb(4'h9), pb(4'h1), pa(4'he), pa(4'hc),
                                  pa(4'h2), pb(4'hc), pb(4'h8), pb(4'h7), pb(4'h6)};
      3'h5: adv_timer_pins_nxt = {pb(4'h7), pa(4'h1), pa(4'he), pa(4'hc),
                                  pa(4'h3), pb(4'h6), pb(4'h8), pb(4'h1), pa(4'hd)};
      3'h7: begin
        adv_timer_pins_nxt = {pb(4'hf), pb(4'he), pb(4'hd), pb(4'hc),
                              pa(4'hb), pa(4'ha), pa(4'h9), pa(4'h8), pa(4'hc)};
        adv_timer_pins_en_nxt = 1'b0;
        osc_cal_nxt = 1'b1;
      end
      default: adv_timer_pins_nxt = {pb(4'hf), pb(4'he), pb(4'hd), pb(4'hc),
                                     pa(4'hb), pa(4'ha), pa(4'h9), pa(4'h8), pa(4'hc)};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode: general timer {ch4, ch3, ch2, ch1/trigger}

  pin_t [3:0] gen_timer_pins_nxt;

  always_comb begin
    case (gen_timer_code)
      3'h1: gen_timer_pins_nxt = {pa(4'h3), pa(4'h2), pb(4'h3), pa(4'hf)};
      3'h2: gen_timer_pins_nxt = {pb(4'hb), pb(4'ha), pa(4'h1), pa(4'h0)};
      3'h3: gen_timer_pins_nxt = {pb(4'hb), pb(4'ha), pb(4'h3), pa(4'hf)};
      3'h4: gen_timer_pins_nxt = {pa(4'h6), pb(4'hc), pa(4'h2), pa(4'h3)};
      3'h5: gen_timer_pins_nxt = {pa(4'h6), pb(4'hc), pa(4'h2), pa(4'hc)};
      3'h7: gen_timer_pins_nxt = {pa(4'h4), pa(4'h5), pb(4'h8), pa(4'hc)};
      default: gen_timer_pins_nxt = {pa(4'h3), pa(4'h2), pa(4'h1), pa(4'h0)};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode: serial ports {rts, cts, clock, receive, transmit}

  pin_t [4:0] serial_port_a_pins_nxt;
  pin_t [4:0] serial_port_b_pins_nxt;
  pin_t [4:0] serial_port_d_pins_nxt;

  always_comb begin
    case (serial_port_a_code)
      3'h1: serial_port_a_pins_nxt = {pa(4'hc), pa(4'hb), pa(4'h8), pb(4'h7), pb(4'h6)};
      3'h2: serial_port_a_pins_nxt = {pa(4'hd), pa(4'h2), pa(4'h3), pa(4'h5), pa(4'h4)};
      3'h3: serial_port_a_pins_nxt = {pb(4'h8), pb(4'h7), pa(4'h6), pa(4'h4), pa(4'h5)};
      3'h4: serial_port_a_pins_nxt = {pa(4'hd), pa(4'he), pa(4'h6), pb(4'h9), pb(4'hb)};
      3'h5: serial_port_a_pins_nxt = {pb(4'h8), pb(4'h7), pb(4'h6), pa(4'hc), pb(4'hc)};
      default: serial_port_a_pins_nxt = {pa(4'hc), pa(4'hb), pa(4'h8), pa(4'ha), pa(4'h9)};
    endcase
  end

  always_comb begin
    case (serial_port_b_code)
      2'h2: serial_port_b_pins_nxt = {pa(4'h1), pa(4'h0), pa(4'h4), pa(4'hc), pa(4'hb)};
      2'h3: serial_port_b_pins_nxt = {pa(4'h1), pa(4'h0), pa(4'h4), pa(4'hb), pa(4'hc)};
      default: serial_port_b_pins_nxt = {pa(4'h1), pa(4'h0), pa(4'h4), pa(4'h3), pa(4'h2)};
    endcase
  end

  always_comb begin
    if (serial_port_d_pin_sel) begin
      serial_port_d_pins_nxt = {pa(4'hf), pa(4'h7), pa(4'h6), pb(4'h5), pa(4'h5)};
    end else begin
      serial_port_d_pins_nxt = {pb(4'h4), pb(4'h3), pb(4'h2), pb(4'h1), pb(4'h0)};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stages; one cycle behind the register and select inputs

  pin_route_reg #(
    .WIDTH(20),
    .RESET_VAL({pb(4'hf), pb(4'he), pb(4'hd), pb(4'hc)})
  ) u_lowpower_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(lowpower_timer_pins_nxt),
    .q_o(lowpower_timer_pins_o)
  );

  pin_route_reg #(
    .WIDTH(20),
    .RESET_VAL({pa(4'h7), pa(4'h6), pa(4'h5), pa(4'h4)})
  ) u_serial_periph (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(serial_periph_pins_nxt),
    .q_o(serial_periph_pins_o)
  );

  pin_route_reg #(
    .WIDTH(15),
    .RESET_VAL({pb(4'h5), pb(4'h7), pb(4'h6)})
  ) u_twowire (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(twowire_pins_nxt),
    .q_o(twowire_pins_o)
  );

  // Enable and oscillator flag ride in the same stage as the pins
  pin_route_reg #(
    .WIDTH(47),
    .RESET_VAL({1'b1, 1'b0, pb(4'hf), pb(4'he), pb(4'hd), pb(4'hc),
                pa(4'hb), pa(4'ha), pa(4'h9), pa(4'h8), pa(4'hc)})
  ) u_adv_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({adv_timer_pins_en_nxt, osc_cal_nxt, adv_timer_pins_nxt}),
    .q_o({adv_timer_pins_en_o, low_speed_internal_osc_cal_o, adv_timer_pins_o})
  );

  pin_route_reg #(
    .WIDTH(20),
    .RESET_VAL({pa(4'h3), pa(4'h2), pa(4'h1), pa(4'h0)})
  ) u_gen_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(gen_timer_pins_nxt),
    .q_o(gen_timer_pins_o)
  );

  pin_route_reg #(
    .WIDTH(25),
    .RESET_VAL({pa(4'hc), pa(4'hb), pa(4'h8), pa(4'ha), pa(4'h9)})
  ) u_serial_port_a (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(serial_port_a_pins_nxt),
    .q_o(serial_port_a_pins_o)
  );

  pin_route_reg #(
    .WIDTH(25),
    .RESET_VAL({pa(4'h1), pa(4'h0), pa(4'h4), pa(4'h3), pa(4'h2)})
  ) u_serial_port_b (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(serial_port_b_pins_nxt),
    .q_o(serial_port_b_pins_o)
  );

  pin_route_reg #(
    .WIDTH(25),
    .RESET_VAL({pb(4'h4), pb(4'h3), pb(4'h2), pb(4'h1), pb(4'h0)})
  ) u_serial_port_d (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(serial_port_d_pins_nxt),
    .q_o(serial_port_d_pins_o)
  );

endmodule

// [core/pin_route_reg.sv]
// Purpose: Registered stage for one peripheral's pin assignment vector
// Assumes: Reset value is the default mapping, given as a parameter
// Notes: Keeps every routing output straight from a flip-flop
`timescale 1ns/1ps
module pin_route_reg #(
  parameter int WIDTH = 20,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  // Refused at elaboration; a zero-width stage has nothing to hold
  if (WIDTH < 1) begin : g_width_check
    $error("pin_route_reg: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_o <= RESET_VAL;
    end else begin
      q_o <= d_i;
    end
  end

endmodule

// [tb/peripheral_pin_remap_high_sva.sv]
// Purpose: Port checker for the high remap register and its pin selects
// Assumes: Register at offset 0x00; low code bits arrive as level inputs
// Notes: A shadow of accepted writes stands in for the hidden register
`timescale 1ns/1ps
`include "pin_remap_consts.svh"
module peripheral_pin_remap_high_sva
  import pin_remap_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [`REMAP_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic serial_periph_pin_sel_lo_i,
  input wire logic twowire_pin_sel_lo_i,
  input wire logic [1:0] adv_timer_pin_sel_lo_i,
  input wire logic [1:0] gen_timer_pin_sel_lo_i,
  input wire logic serial_port_a_pin_sel_lo_i,
  input wire logic serial_port_b_pin_sel_lo_i,
  input wire pin_t [3:0] lowpower_timer_pins_o,
  input wire pin_t [3:0] serial_periph_pins_o,
  input wire pin_t [2:0] twowire_pins_o,
  input wire pin_t [8:0] adv_timer_pins_o,
  input wire logic adv_timer_pins_en_o,
  input wire logic low_speed_internal_osc_cal_o,
  input wire pin_t [3:0] gen_timer_pins_o,
  input wire pin_t [4:0] serial_port_a_pins_o,
  input wire pin_t [4:0] serial_port_b_pins_o,
  input wire pin_t [4:0] serial_port_d_pins_o
);
  logic [31:0] shd_r;
  logic live_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shd_r <= 32'h0000_0000;
    end else if (wr_i && addr_i == 8'h00) begin
      shd_r <= wdata_i & 32'h03ff_0000;
    end
  end

  // Output stage still shows reset defaults at the first edge after release
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      live_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  ////////////////////////////////////////////////////////////////////////////
  a_rd_value:
    assert property (rd_i && addr_i == 8'h00 |=> rdata_o == $past(shd_r))
    else $error("read data differs from stored value");
  a_rsvd_zero:
    assert property (rd_i |=> rdata_o[31:26] == 6'h00 && rdata_o[15:0] == 16'h0000)
    else $error("reserved bits read nonzero");
  a_rd_unmapped:
    assert property (rd_i && addr_i != 8'h00 |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read nonzero");
  a_lp_pins:
    assert property (live_r |-> lowpower_timer_pins_o == ($past(shd_r[25]) ?
      {5'h12, 5'h16, 5'h17, 5'h15} : {5'h1f, 5'h1e, 5'h1d, 5'h1c}))
    else $error("low-power timer pins wrong");
  a_port_d_pins:
    assert property (live_r |-> serial_port_d_pins_o == ($past(shd_r[16]) ?
      {5'h0f, 5'h07, 5'h06, 5'h15, 5'h05} : {5'h14, 5'h13, 5'h12, 5'h11, 5'h10}))
    else $error("port d pins wrong");
  a_alert_fixed:
    assert property (twowire_pins_o[2] == 5'h15)
    else $error("alert pin moved");
  a_spi_clock:
    assert property (live_r |-> serial_periph_pins_o[1] == ($past(shd_r[24]) ? 5'h16 :
      ($past(serial_periph_pin_sel_lo_i) ? 5'h13 : 5'h05)))
    else $error("serial periph clock pin wrong");
  a_osc_cal:
    assert property (live_r |-> low_speed_internal_osc_cal_o ==
      ($past(shd_r[22]) && $past(adv_timer_pin_sel_lo_i) == 2'b11) &&
      adv_timer_pins_en_o != low_speed_internal_osc_cal_o)
    else $error("oscillator calibration select wrong");
  a_portb_tx:
    assert property (live_r |-> serial_port_b_pins_o[0] == (!$past(shd_r[18]) ? 5'h02 :
      ($past(serial_port_b_pin_sel_lo_i) ? 5'h0c : 5'h0b)))
    else $error("port b transmit pin wrong");
endmodule

bind peripheral_pin_remap_high peripheral_pin_remap_high_sva u_sva (
  .clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .serial_periph_pin_sel_lo_i, .twowire_pin_sel_lo_i, .adv_timer_pin_sel_lo_i,
  .gen_timer_pin_sel_lo_i, .serial_port_a_pin_sel_lo_i, .serial_port_b_pin_sel_lo_i,
  .lowpower_timer_pins_o, .serial_periph_pins_o, .twowire_pins_o, .adv_timer_pins_o,
  .adv_timer_pins_en_o, .low_speed_internal_osc_cal_o, .gen_timer_pins_o,
  .serial_port_a_pins_o, .serial_port_b_pins_o, .serial_port_d_pins_o
);

// [tb/peripheral_pin_remap_high_tb.sv]
// Purpose: Self-checking bench for the high remap register block
// Assumes: Pin code {port, number}, port A 0, port B 1
// Notes: One sweep sets every code of every field at once
`timescale 1ns/1ps
module peripheral_pin_remap_high_tb
  import pin_remap_pkg::*;
;
  logic clk_i, resetn_i, wr_i, rd_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic spi_lo, tw_lo, pa_lo, pb_lo, adv_en, osc_cal;
  logic [1:0] adv_lo, gen_lo;
  logic [2:0] c;
  pin_t [3:0] lp_o, spi_o, gen_o;
  pin_t [2:0] tw_o;
  pin_t [8:0] adv_o;
  pin_t [4:0] pa_o, pb_o, pd_o;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [44:0] adv_dflt =
    {5'h1f, 5'h1e, 5'h1d, 5'h1c, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h0c};
  localparam logic [24:0] pa_dflt = {5'h0c, 5'h0b, 5'h08, 5'h0a, 5'h09};
  logic [19:0] lp_t [2] = '{{5'h1f, 5'h1e, 5'h1d, 5'h1c}, {5'h12, 5'h16, 5'h17, 5'h15}};
  logic [19:0] spi_t [4] = '{{5'h07, 5'h06, 5'h05, 5'h04}, {5'h15, 5'h14, 5'h13, 5'h0f},
    {5'h17, 5'h18, 5'h16, 5'h0c}, {5'h17, 5'h18, 5'h16, 5'h1c}};
  logic [14:0] tw_t [4] = '{{5'h15, 5'h17, 5'h16}, {5'h15, 5'h17, 5'h16},
    {5'h15, 5'h0c, 5'h0d}, {5'h15, 5'h1b, 5'h19}};
  logic [44:0] adv_t [8] = '{adv_dflt,
    {5'h11, 5'h10, 5'h07, 5'h06, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h0c},
    {5'h19, 5'h10, 5'h1b, 5'h0d, 5'h11, 5'h0e, 5'h07, 5'h01, 5'h16},
    {5'h19, 5'h10, 5'h1b, 5'h0d, 5'h11, 5'h0e, 5'h07, 5'h01, 5'h03},
    {5'h19, 5'h11, 5'h0e, 5'h0c, 5'h02, 5'h1c, 5'h18, 5'h17, 5'h16},
    {5'h17, 5'h01, 5'h0e, 5'h0c, 5'h03, 5'h16, 5'h18, 5'h11, 5'h0d}, adv_dflt, adv_dflt};
  logic [19:0] gen_t [8] = '{{5'h03, 5'h02, 5'h01, 5'h00}, {5'h03, 5'h02, 5'h13, 5'h0f},
    {5'h1b, 5'h1a, 5'h01, 5'h00}, {5'h1b, 5'h1a, 5'h13, 5'h0f}, {5'h06, 5'h1c, 5'h02, 5'h03},
    {5'h06, 5'h1c, 5'h02, 5'h0c}, {5'h03, 5'h02, 5'h01, 5'h00}, {5'h04, 5'h05, 5'h18, 5'h0c}};
  logic [24:0] pa_t [8] = '{pa_dflt, {5'h0c, 5'h0b, 5'h08, 5'h17, 5'h16},
    {5'h0d, 5'h02, 5'h03, 5'h05, 5'h04}, {5'h18, 5'h17, 5'h06, 5'h04, 5'h05},
    {5'h0d, 5'h0e, 5'h06, 5'h19, 5'h1b}, {5'h18, 5'h17, 5'h16, 5'h0c, 5'h1c}, pa_dflt, pa_dflt};
  logic [24:0] pb_t [4] = '{{5'h01, 5'h00, 5'h04, 5'h03, 5'h02},
    {5'h01, 5'h00, 5'h04, 5'h03, 5'h02}, {5'h01, 5'h00, 5'h04, 5'h0c, 5'h0b},
    {5'h01, 5'h00, 5'h04, 5'h0b, 5'h0c}};
  logic [24:0] pd_t [2] = '{{5'h14, 5'h13, 5'h12, 5'h11, 5'h10},
    {5'h0f, 5'h07, 5'h06, 5'h15, 5'h05}};

  peripheral_pin_remap_high u_dut (
    .clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .serial_periph_pin_sel_lo_i(spi_lo), .twowire_pin_sel_lo_i(tw_lo),
    .adv_timer_pin_sel_lo_i(adv_lo), .gen_timer_pin_sel_lo_i(gen_lo),
    .serial_port_a_pin_sel_lo_i(pa_lo), .serial_port_b_pin_sel_lo_i(pb_lo),
    .lowpower_timer_pins_o(lp_o), .serial_periph_pins_o(spi_o), .twowire_pins_o(tw_o),
    .adv_timer_pins_o(adv_o), .adv_timer_pins_en_o(adv_en),
    .low_speed_internal_osc_cal_o(osc_cal), .gen_timer_pins_o(gen_o),
    .serial_port_a_pins_o(pa_o), .serial_port_b_pins_o(pb_o), .serial_port_d_pins_o(pd_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  function automatic logic [31:0] word(input logic [2:0] i);
    return {6'h00, i[0], i[1], i[1], i[2], i[2], i[2], i[1], i[1], i[0], i[0], 16'h0000};
  endfunction

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    while (cyc < 3000) begin
      @(posedge clk_i);
      cyc++;
    end
    failures++;
    finish_test;
  end

  initial begin
    resetn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    {spi_lo, tw_lo, pa_lo, pb_lo, adv_lo, gen_lo} = 8'h00;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(8'h00, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h03ff_0000);
    wr(8'h04, 32'h0);
    rd(8'h00, 32'h03ff_0000);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h0002_0000);
    rd(8'h00, 32'h0002_0000);
    $display("End of register access");
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(8'h00, word(c));
      @(posedge clk_i);
      {spi_lo, tw_lo, pa_lo, pb_lo} <= {4{c[0]}};
      adv_lo <= c[1:0];
      gen_lo <= c[1:0];
      repeat (3) @(posedge clk_i);
      #1;
      chk(lp_o, lp_t[c[0]]);
      chk(spi_o, spi_t[c[1:0]]);
      chk(tw_o, tw_t[c[1:0]]);
      chk(adv_o, adv_t[c]);
      chk({adv_en, osc_cal}, (c == 3'h7) ? 2'b01 : 2'b10);
      chk(gen_o, gen_t[c]);
      chk(pa_o, pa_t[c]);
      chk(pb_o, pb_t[c[1:0]]);
      chk(pd_o, pd_t[c[0]]);
      rd(8'h00, word(c));
    end
    $display("End of code sweep");
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    // Outputs fall back to code 0 pins while reset is held
    chk(spi_o, spi_t[0]);
    chk(rdata_o, 32'h0);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(8'h00, 32'h0);
    // Low inputs still carry the last sweep code; high bits are back to 0
    chk(lp_o, lp_t[0]);
    chk(adv_o, adv_t[3]);
    chk({adv_en, osc_cal}, 2'b10);
    chk(pd_o, pd_t[0]);
    $display("End of second reset");
    finish_test;
  end
endmodule
